/* logic/csir_aux_if.sv */
// csir_aux_if: port between register front end and auxiliary byte store
// assumes: one read and one write port, read data registered in the store
`timescale 1ns/100ps
interface csir_aux_if #(parameter int AW = 5);
	logic rd_en;
	logic [AW-1:0] rd_addr;
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport ctrl(output rd_en, rd_addr, wr_en, wr_addr, wdata, input rdata);
	modport store(input rd_en, rd_addr, wr_en, wr_addr, wdata, output rdata);
endinterface

/* logic/csir_aux_mem.sv */
// csir_aux_mem: auxiliary byte registers behind the extended data index
// assumes: single clock, async active-high reset, one read and one write per cycle
`timescale 1ns/100ps
module csir_aux_mem #(
	parameter int AW = 5
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// access port
	csir_aux_if.store aux
);
	import csir_pkg::*;

	typedef struct packed {
		logic [(1 << AW)-1:0][7:0] mem;
		logic [7:0] rdata;
	} csir_mem_t;

	csir_mem_t r_reg;
	csir_mem_t r_next;

	always_comb begin
		r_next = r_reg;
		if (aux.wr_en) begin
			r_next.mem[aux.wr_addr] = aux.wdata;
		end
		// write-first: a pipelined read right after a write sees new data
		if (aux.rd_en) begin
			r_next.rdata = r_next.mem[aux.rd_addr];
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign aux.rdata = r_reg.rdata;

endmodule // csir_aux_mem

/* logic/csir_pkg.sv */
// csir_pkg: constants and types for the socket id/ata/index register block
// assumes: 100 MHz clk_sys, registers addressed as byte address = 4 * index
package csir_pkg;

	// ----------------------------------------------------------------
	// register indices
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_MISC = 8'h1E;
	localparam logic [7:0] IDX_ID = 8'h1F;
	localparam logic [7:0] IDX_ATA = 8'h26;
	localparam logic [7:0] IDX_EXT_SEL = 8'h2E;
	localparam logic [7:0] IDX_EXT_DATA = 8'h2F;
	localparam logic [7:0] IDX_SOCK_B = 8'h40;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h50;
	localparam logic [7:0] IDX_IRQ_EN = 8'h51;
	localparam logic [7:0] IDX_IRQ_CLR = 8'h52;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int MISC_RING_BIT = 7;
	localparam int MISC_LAMP_BIT = 4;
	localparam int ATA_MODE_BIT = 0;
	localparam int ATA_LAMP_BIT = 1;
	localparam int ATA_SCRATCH_BIT = 2;
	localparam int ATA_ADDR_LSB = 3;
	localparam int ATA_ADDR_W = 5;
	localparam int ID_SIG_LSB = 6;
	localparam int ID_DUAL_BIT = 5;
	localparam int ID_REV_LSB = 1;
	localparam int N_EVENTS = 2;

	// ----------------------------------------------------------------
	// reset and fixed values
	// ----------------------------------------------------------------
	localparam logic [7:0] MISC_RST = 8'h00;
	localparam logic [7:0] ATA_CTL_RST = 8'h00;
	localparam logic [7:0] EXT_SEL_RST = 8'h00;
	localparam logic [7:0] AUX_RST = 8'h00;
	localparam logic [1:0] ID_SIG_FIRST = 2'h3;
	localparam logic [1:0] ID_SIG_SECOND = 2'h0;
	localparam logic [7:0] EXT_RSVD_LO = 8'h05;
	localparam logic [7:0] EXT_RSVD_HI = 8'h09;
	localparam logic [7:0] EXT_LAST = 8'h0B;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int RING_PULSE_NS = 1000;
	localparam int RING_PULSE_CYC = (RING_PULSE_NS * CLK_MHZ) / 1000;

	// ----------------------------------------------------------------
	// bus state machine
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WRITE = 4'h2,
		ST_RD_WAIT = 4'h4,
		ST_RD_DONE = 4'h8
	} csir_bus_st_t;

endpackage

/* logic/csir_regs.sv */
// csir_regs: id, ata_socket_control and extended index registers of a socket ctrl
// assumes: AHB-Lite single word transfers, byte address = 4 * index,
// card pins asynchronous, irq sources from same-clock logic
`timescale 1ns/100ps
module csir_regs #(
	parameter logic DUAL = 1'b1,
	parameter logic [3:0] REVISION = 4'h5 // arbitrary value
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// card pins, active low, asynchronous
	input wire logic [1:0] stschg_n,
	input wire logic [1:0] spkr_n,
	// normal irq sources from system logic
	input wire logic irq15_src,
	input wire logic irq12_src,
	// isa irq pins
	output logic irq15_out,
	output logic irq12_out,
	output logic irq12_oe,
	// socket configuration
	output logic [1:0] ata_mode,
	output logic [1:0] audio_pin_as_lamp,
	output logic [1:0][csir_pkg::ATA_ADDR_W-1:0] ata_high_addr,
	// interrupt
	output logic irq_out
);
	import csir_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		csir_bus_st_t st;
		logic [7:0] a_idx;
		logic a_ok;
		logic hready;
		logic [31:0] hrdata;
		logic [7:0] misc;
		logic id_first;
		logic [1:0][7:0] ata_ctl;
		logic [1:0][7:0] ext_sel;
		logic [1:0] stschg_prev;
		logic [N_EVENTS-1:0] irq_stat;
		logic [N_EVENTS-1:0] irq_en;
		logic irq;
		logic [15:0] ring_cnt;
		logic irq15;
		logic irq12;
		logic irq12_oe;
		logic [1:0] ata_mode;
		logic [1:0] lamp_sel;
		logic [1:0][ATA_ADDR_W-1:0] ata_addr;
	} csir_regs_t;

	csir_regs_t r_reg;
	csir_regs_t r_next;

	logic [1:0] stschg_sync;
	logic [1:0] spkr_sync;

	csir_aux_if #(.AW(5)) aux ();

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic ext_ok(input logic [7:0] e);
		ext_ok = (e <= EXT_LAST) && !(e >= EXT_RSVD_LO && e <= EXT_RSVD_HI);
	endfunction

	function automatic logic sock_ok(input logic [7:0] idx);
		sock_ok = !idx[6] || DUAL;
	endfunction

	function automatic logic [7:0] base_of(input logic [7:0] idx);
		base_of = idx & ~IDX_SOCK_B;
	endfunction

	// ----------------------------------------------------------------
	// sub-blocks
	// ----------------------------------------------------------------
	csir_sync #(.W(2), .RST(2'h3)) u_sync_stschg (
		.clk_sys(clk_sys),
		.reset(reset),
		.d(stschg_n),
		.q(stschg_sync)
	);

	csir_sync #(.W(2), .RST(2'h3)) u_sync_spkr (
		.clk_sys(clk_sys),
		.reset(reset),
		.d(spkr_n),
		.q(spkr_sync)
	);

	csir_aux_mem #(.AW(5)) u_aux (
		.clk_sys(clk_sys),
		.reset(reset),
		.aux(aux)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic accept;
		logic [7:0] nidx;
		logic [7:0] base;
		logic s;
		logic [7:0] rd;
		logic [N_EVENTS-1:0] clr;
		logic [1:0] fall;
		logic lamp_on;
		accept = 1'b0;
		nidx = haddr[9:2];
		base = 8'h00;
		s = 1'b0;
		rd = 8'h00;
		clr = '0;
		fall = r_reg.stschg_prev & ~stschg_sync;
		lamp_on = 1'b0;
		r_next = r_reg;
		aux.rd_en = 1'b0;
		aux.rd_addr = {nidx[6], r_reg.ext_sel[nidx[6]][3:0]};
		aux.wr_en = 1'b0;
		aux.wr_addr = {r_reg.a_idx[6], r_reg.ext_sel[r_reg.a_idx[6]][3:0]};
		aux.wdata = hwdata[7:0];

		// no wait state on writes; reads take one, the aux store is clocked
		if (r_reg.st != ST_RD_WAIT) begin
			accept = hsel && hready && htrans == HTRANS_NONSEQ;
		end

		base = base_of(r_reg.a_idx);
		s = r_reg.a_idx[6];
		case (r_reg.st)
			ST_WRITE: begin
				if (r_reg.a_ok) begin
					if (r_reg.a_idx == IDX_MISC) begin
						r_next.misc[MISC_RING_BIT] = hwdata[MISC_RING_BIT];
						r_next.misc[MISC_LAMP_BIT] = hwdata[MISC_LAMP_BIT];
					end
					if (r_reg.a_idx == IDX_ID) begin
						r_next.id_first = 1'b1;
					end
					if (r_reg.a_idx == IDX_IRQ_EN) begin
						r_next.irq_en = hwdata[N_EVENTS-1:0];
					end
					if (r_reg.a_idx == IDX_IRQ_CLR) begin
						clr = hwdata[N_EVENTS-1:0];
					end
					if (sock_ok(r_reg.a_idx) && base == IDX_ATA) begin
						r_next.ata_ctl[s] = hwdata[7:0];
					end
					if (DUAL && base == IDX_EXT_SEL) begin
						r_next.ext_sel[s] = hwdata[7:0];
					end
					if (DUAL && base == IDX_EXT_DATA) begin
						aux.wr_en = ext_ok(r_reg.ext_sel[s]);
					end
				end
				r_next.st = ST_IDLE;
			end
			ST_RD_WAIT: begin
				if (r_reg.a_ok) begin
					if (r_reg.a_idx == IDX_MISC) begin
						rd[MISC_RING_BIT] = r_reg.misc[MISC_RING_BIT];
						rd[MISC_LAMP_BIT] = r_reg.misc[MISC_LAMP_BIT];
					end
					if (r_reg.a_idx == IDX_ID) begin
						rd[7:ID_SIG_LSB] = r_reg.id_first ? ID_SIG_FIRST
							: ID_SIG_SECOND;
						rd[ID_DUAL_BIT] = DUAL;
						rd[ID_DUAL_BIT-1:ID_REV_LSB] = REVISION;
						rd[0] = DUAL;
						r_next.id_first = !r_reg.id_first;
					end
					if (r_reg.a_idx == IDX_IRQ_STAT) begin
						rd[N_EVENTS-1:0] = r_reg.irq_stat;
					end
					if (r_reg.a_idx == IDX_IRQ_EN) begin
						rd[N_EVENTS-1:0] = r_reg.irq_en;
					end
					if (sock_ok(r_reg.a_idx) && base == IDX_ATA) begin
						rd = r_reg.ata_ctl[s];
					end
					if (DUAL && base == IDX_EXT_SEL) begin
						rd = r_reg.ext_sel[s];
					end
					// reserved aux slots read as zero
					if (DUAL && base == IDX_EXT_DATA && ext_ok(r_reg.ext_sel[s])) begin
						rd = aux.rdata;
					end
				end
				r_next.hrdata = {24'h000000, rd};
				r_next.hready = 1'b1;
				r_next.st = ST_RD_DONE;
			end
			ST_IDLE, ST_RD_DONE: begin
				r_next.st = ST_IDLE;
			end
			default: begin
				r_next.st = ST_IDLE;
			end
		endcase

		// address phase capture
		if (accept) begin
			r_next.a_idx = nidx;
			r_next.a_ok = haddr[31:10] == 22'h000000 && haddr[1:0] == 2'h0;
			if (hwrite) begin
				r_next.st = ST_WRITE;
			end else begin
				r_next.st = ST_RD_WAIT;
				r_next.hready = 1'b0;
				aux.rd_en = 1'b1;
				// a select written in this same cycle must steer the read
				aux.rd_addr = {nidx[6], r_next.ext_sel[nidx[6]][3:0]};
			end
		end

		// ----------------------------------------------------------------
		// events and interrupt; a new event wins over a clear
		// ----------------------------------------------------------------
		r_next.stschg_prev = stschg_sync;
		if (!DUAL) begin
			fall[1] = 1'b0;
		end
		r_next.irq_stat = (r_reg.irq_stat & ~clr) | fall;
		r_next.irq = |(r_next.irq_stat & r_reg.irq_en);

		// ring wake pulse stretched so a slow host pin sees it
		if (r_reg.misc[MISC_RING_BIT] && |fall) begin
			r_next.ring_cnt = 16'(RING_PULSE_CYC);
		end else if (r_reg.ring_cnt != 16'h0000) begin
			r_next.ring_cnt = r_reg.ring_cnt - 16'h0001;
		end
		if (r_reg.misc[MISC_RING_BIT]) begin
			r_next.irq15 = r_next.ring_cnt != 16'h0000;
		end else begin
			r_next.irq15 = irq15_src;
		end

		// ----------------------------------------------------------------
		// socket outputs
		// ----------------------------------------------------------------
		for (int i = 0; i < 2; i++) begin
			r_next.ata_mode[i] = r_reg.ata_ctl[i][ATA_MODE_BIT];
			r_next.lamp_sel[i] = r_reg.ata_ctl[i][ATA_LAMP_BIT];
			if (r_reg.ata_ctl[i][ATA_MODE_BIT]) begin
				r_next.ata_addr[i] = r_reg.ata_ctl[i][7:ATA_ADDR_LSB];
			end else begin
				r_next.ata_addr[i] = '0;
			end
			if (r_reg.ata_ctl[i][ATA_LAMP_BIT] && !spkr_sync[i]) begin
				lamp_on = 1'b1;
			end
		end
		if (!DUAL) begin
			r_next.ata_mode[1] = 1'b0;
			r_next.lamp_sel[1] = 1'b0;
			r_next.ata_addr[1] = '0;
		end

		// lamp mode: open drain, pulled low while the card lamp is on
		if (r_reg.misc[MISC_LAMP_BIT]) begin
			r_next.irq12 = 1'b0;
			r_next.irq12_oe = lamp_on;
		end else begin
			r_next.irq12 = irq12_src;
			r_next.irq12_oe = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			r_reg <= '0;
			r_reg.st <= ST_IDLE;
			r_reg.hready <= 1'b1;
			r_reg.misc <= MISC_RST;
			r_reg.id_first <= 1'b1;
			r_reg.ata_ctl <= {ATA_CTL_RST, ATA_CTL_RST};
			r_reg.ext_sel <= {EXT_SEL_RST, EXT_SEL_RST};
			r_reg.stschg_prev <= 2'h3;
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign hreadyout = r_reg.hready;
	assign hresp = 1'b0;
	assign hrdata = r_reg.hrdata;
	assign irq15_out = r_reg.irq15;
	assign irq12_out = r_reg.irq12;
	assign irq12_oe = r_reg.irq12_oe;
	assign ata_mode = r_reg.ata_mode;
	assign audio_pin_as_lamp = r_reg.lamp_sel;
	assign ata_high_addr = r_reg.ata_addr;
	assign irq_out = r_reg.irq;

endmodule // csir_regs

/* logic/csir_sync.sv */
// csir_sync: two-flop synchroniser for pin levels
// assumes: inputs are slow levels, no pulse shorter than two clocks
`timescale 1ns/100ps
module csir_sync #(
	parameter int W = 2,
	parameter logic [W-1:0] RST = '1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} csir_sync_t;

	csir_sync_t r_reg;
	csir_sync_t r_next;

	always_comb begin
		r_next.s1 = d;
		r_next.s2 = r_reg.s1;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			r_reg <= {RST, RST};
		end else begin
			r_reg <= r_next;
		end
	end

	assign q = r_reg.s2;

endmodule // csir_sync

/* verification/csir_card_model.sv */
// csir_card_model: card side of the socket, status-change and lamp pins
// assumes: pins pulled up when released, LAG of at least 2 cycles
`timescale 1ns/100ps
module csir_card_model #(
	parameter int LAG = 2
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// requests from the bench
	input wire logic [1:0] evt,
	input wire logic [1:0] lamp_on,
	// socket pins
	output logic [1:0] stschg_n,
	output logic [1:0] spkr_n
);
	logic [LAG-1:0][3:0] pipe;
	// a slow card: pin edges follow the requests LAG clk_sys edges later
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pipe <= '0;
		end else begin
			pipe <= {pipe[LAG-2:0], lamp_on, evt};
		end
	end
	assign stschg_n = ~pipe[LAG-1][1:0];
	assign spkr_n = ~pipe[LAG-1][3:2];
endmodule // csir_card_model

/* verification/csir_regs_chk.sv */
// csir_regs_chk: port assertions for the socket register block
// assumes: bound to csir_regs, one slave, byte address = 4 * index
`timescale 1ns/100ps
module csir_regs_chk (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hreadyout,
	// card pins and irq
	input wire logic [1:0] stschg_n,
	input wire logic [1:0] spkr_n,
	input wire logic irq15_src,
	input wire logic irq12_src,
	input wire logic irq15_out,
	input wire logic irq12_out,
	input wire logic irq12_oe,
	// socket configuration
	input wire logic [1:0] ata_mode,
	input wire logic [1:0] audio_pin_as_lamp,
	input wire logic [1:0][csir_pkg::ATA_ADDR_W-1:0] ata_high_addr
);
	import csir_pkg::*;
	// ----------------
	// write shadow
	// ----------------
	logic wp;
	logic ring;
	logic lamp;
	logic [1:0] up;
	logic [9:0] wa;
	logic [1:0][7:0] ata;
	// shadow tracks only the registers whose effect shows at the pins
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wp <= 1'b0;
			ring <= 1'b0;
			lamp <= 1'b0;
			up <= 2'h0;
			wa <= 10'h0;
			ata <= '0;
		end else begin
			up <= {up[0], 1'b1};
			if (hreadyout) begin
				wp <= hsel && htrans == HTRANS_NONSEQ && hwrite;
				wa <= haddr[9:0];
			end
			if (wp && wa == 10'h078) begin
				ring <= hwdata[MISC_RING_BIT];
				lamp <= hwdata[MISC_LAMP_BIT];
			end
			if (wp && {wa[9], wa[7:0]} == 9'h098) begin
				ata[wa[8]] <= hwdata[7:0];
			end
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	AST_RING_NORMAL: assert property (up[1] && !ring && !$past(ring)
		|-> irq15_out == $past(irq15_src)) else $error("irq15 not normal");
	AST_RING_WAKE: assert property (ring && $fell(stschg_n[0])
		|-> ##[1:8] irq15_out) else $error("no ring wake pulse");
	AST_RING_HOLD: assert property (ring && $past(ring) && $rose(irq15_out)
		|-> irq15_out[*8]) else $error("ring pulse too short");
	AST_ATA_MODE: assert property (ata_mode ==
		{$past(ata[1][0]), $past(ata[0][0])}) else $error("ata mode wrong");
	AST_LAMP_BIT: assert property (audio_pin_as_lamp ==
		{$past(ata[1][1]), $past(ata[0][1])}) else $error("lamp pin wrong");
	AST_ADDR_A: assert property (ata_high_addr[0] == ($past(ata[0][0]) ?
		$past(ata[0][7:3]) : 5'h00)) else $error("socket a address wrong");
	AST_ADDR_B: assert property (ata_high_addr[1] == ($past(ata[1][0]) ?
		$past(ata[1][7:3]) : 5'h00)) else $error("socket b address wrong");
	AST_READ_WAIT: assert property (hsel && hreadyout && !hwrite &&
		htrans == HTRANS_NONSEQ |=> !hreadyout ##1 hreadyout)
		else $error("read wait wrong");
	AST_LAMP_ON: assert property ((lamp && ata[0][1] && !spkr_n[0])[*6]
		|-> irq12_oe && !irq12_out) else $error("lamp not driven");
	AST_LAMP_OFF: assert property ((up[1] && lamp && spkr_n == 2'h3)[*6]
		|-> !irq12_oe) else $error("lamp driven while off");
	AST_IRQ12_NORMAL: assert property (up[1] && !lamp && !$past(lamp)
		|-> irq12_oe && irq12_out == $past(irq12_src))
		else $error("irq12 not normal");
endmodule // csir_regs_chk

/* verification/csir_regs_test.sv */
// csir_regs_test: self-checking bench for the socket register block
// assumes: csir_regs with both sockets, card model on the socket pins
`timescale 1ns/100ps
module csir_regs_test;
	import csir_pkg::*;
	// ----------------
	// signals
	// ----------------
	localparam logic [3:0] REV = 4'h9; // arbitrary value
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic rd_dp = 1'b0;
	logic irq15_src = 1'b0;
	logic irq12_src = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [1:0] evt = 2'h0;
	logic [1:0] lamp_on = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] lf = 32'h7FE2;
	logic [31:0] hrdata;
	logic hreadyout, hresp, irq15_out, irq12_out, irq12_oe, irq_out, r;
	logic [1:0] stschg_n, spkr_n, ata_mode, apl;
	logic [1:0][ATA_ADDR_W-1:0] aha;
	logic [7:0] a, b, v;
	logic [31:0] exp_q[$];
	int num_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	csir_regs #(.DUAL(1'b1), .REVISION(REV)) uut (.clk_sys(clk_sys),
		.reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.stschg_n(stschg_n), .spkr_n(spkr_n), .irq15_src(irq15_src),
		.irq12_src(irq12_src), .irq15_out(irq15_out), .irq12_out(irq12_out),
		.irq12_oe(irq12_oe), .ata_mode(ata_mode), .audio_pin_as_lamp(apl),
		.ata_high_addr(aha), .irq_out(irq_out));
	csir_card_model #(.LAG(2)) card (.clk_sys(clk_sys), .reset(reset),
		.evt(evt), .lamp_on(lamp_on), .stschg_n(stschg_n), .spkr_n(spkr_n));
	always #5 clk_sys = ~clk_sys;
	// ----------------
	// tasks
	// ----------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] idv(input logic [1:0] s);
		return {24'h0, s, 1'b1, REV, 1'b1};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %0h, expected %0h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		if (num_errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// single transfer; hreadyout read before this edge's updates land
	task automatic bus(input logic [31:0] ad, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= ad;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge clk_sys); while (!hreadyout);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (!hreadyout);
	endtask
	task automatic wr(input logic [31:0] ad, input logic [31:0] d);
		bus(ad, 1'b1, d);
	endtask
	task automatic rd(input logic [31:0] ad, input logic [31:0] e);
		exp_q.push_back(e);
		bus(ad, 1'b0, 32'h0);
	endtask
	// random irq sources, timeout and read data scoreboard
	always @(posedge clk_sys) begin
		lf <= lfsr(lf);
		irq15_src <= lf[3];
		irq12_src <= lf[9];
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			num_errors++;
			print_verdict();
		end
		if (rd_dp && hreadyout) begin
			chk(hrdata, exp_q.pop_front());
			chk(32'(hresp), 32'h0);
		end
		if (hreadyout) begin
			rd_dp <= hsel && htrans == HTRANS_NONSEQ && !hwrite;
		end
	end
	// ----------------
	// scenarios
	// ----------------
	initial begin
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		rd(32'h98, 32'h0);
		rd(32'h198, 32'h0);
		for (int i = 0; i < 3; i++) begin
			rd(32'h7C, idv(i[0] ? 2'h0 : 2'h3));
		end
		wr(32'h7C, 32'h0);
		rd(32'h7C, idv(2'h3));
		rd(32'h17C, 32'h0);
		for (int i = 0; i < 8; i++) begin
			a = {lf[7:2], lf[1] & i[0], i[0]};
			b = {lf[15:10], lf[9] & ~i[0], ~i[0]};
			wr(32'h98, {24'h0, a});
			wr(32'h198, {24'h0, b});
			rd(32'h98, {24'h0, a});
			rd(32'h198, {24'h0, b});
			chk(32'(ata_mode), {30'h0, b[0], a[0]});
			chk(32'(apl), {30'h0, b[1], a[1]});
			chk(32'(aha), {22'h0, b[0] ? b[7:3] : 5'h0, a[0] ? a[7:3] : 5'h0});
		end
		for (int k = 0; k < 13; k++) begin
			v = lf[7:0];
			r = (k >= 5 && k <= 9) || k > 11;
			wr(32'hB8, 32'(k));
			wr(32'hBC, {24'h0, v});
			wr(32'h1B8, 32'(k));
			wr(32'h1BC, {24'h0, ~v});
			rd(32'hB8, 32'(k));
			rd(32'hBC, {24'h0, r ? 8'h0 : v});
			rd(32'h1BC, {24'h0, r ? 8'h0 : ~v});
		end
		wr(32'h3F0, 32'hFF);
		rd(32'h3F0, 32'h0);
		wr(32'h78, 32'h80);
		evt[0] <= 1'b1;
		repeat (10) @(posedge clk_sys);
		chk(32'(irq15_out), 32'h1);
		evt[0] <= 1'b0;
		repeat (100) @(posedge clk_sys);
		chk(32'(irq15_out), 32'h0);
		wr(32'h144, 32'h1);
		rd(32'h140, 32'h1);
		chk(32'(irq_out), 32'h1);
		wr(32'h144, 32'h0);
		rd(32'h140, 32'h1);
		chk(32'(irq_out), 32'h0);
		wr(32'h144, 32'h1);
		wr(32'h148, 32'h1);
		rd(32'h140, 32'h0);
		chk(32'(irq_out), 32'h0);
		wr(32'h78, 32'h0);
		evt[1] <= 1'b1;
		repeat (10) @(posedge clk_sys);
		rd(32'h140, 32'h2);
		wr(32'h98, 32'h3);
		wr(32'h78, 32'h10);
		lamp_on[0] <= 1'b1;
		repeat (10) @(posedge clk_sys);
		chk({irq12_oe, irq12_out}, 32'h2);
		lamp_on[0] <= 1'b0;
		repeat (10) @(posedge clk_sys);
		chk(32'(irq12_oe), 32'h0);
		reset <= 1'b1;
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		rd(32'h98, 32'h0);
		rd(32'h7C, idv(2'h3));
		repeat (2) @(posedge clk_sys);
		print_verdict();
	end
endmodule // csir_regs_test
bind csir_regs csir_regs_chk chk (.clk_sys(clk_sys), .reset(reset),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hreadyout(hreadyout), .stschg_n(stschg_n),
	.spkr_n(spkr_n), .irq15_src(irq15_src), .irq12_src(irq12_src),
	.irq15_out(irq15_out), .irq12_out(irq12_out), .irq12_oe(irq12_oe),
	.ata_mode(ata_mode), .audio_pin_as_lamp(audio_pin_as_lamp),
	.ata_high_addr(ata_high_addr));
